// file: pkg/tap_pkg.sv
// Purpose: shared constants and types for the memory test access port
// Assumes: both ends run on pclk at 125 MHz; the test clock is a link signal
// Notes: tags below mark the logic that carries each rule
// Function
// RULE_01: sixteen-state controller, self reset at power-up
// RULE_02: sample on test clock rise, drive on fall
// RULE_03: data-out driven only in shift states
// RULE_04: serial in at MSB, out at LSB
// RULE_05: instruction selects exactly one data register
// RULE_06: five mode-select highs reach reset state
// RULE_07: instruction loads in update, resets to ID-read
// RULE_08: capture loads 01 into instruction LSBs
// RULE_09: one-bit bypass, cleared when bypass takes effect
// RULE_10: ID-read capture loads fixed 32-bit code
// RULE_11: boundary chain captures pin ring, shifts
// RULE_12: controller shifts instruction, then passes update
// RULE_13: external test drives preloaded outputs from update
// RULE_14: floated sample: outputs off, chain captures
// RULE_15: sample/preload snapshots pins, transitions unsure
// RULE_16: test clock at most 50 MHz
// RULE_17: ignore captured main clock bits if running
// RULE_18: bypass bit sits between data in/out
// RULE_19: never issue reserved instruction codes
// RULE_20: test clock held low leaves port idle
// RULE_21: decode the five listed 3-bit codes
// RULE_22: 3-bit instruction register, 109-cell chain
package tap_pkg;

    localparam int IR_W    = 3;   // RULE_22
    localparam int ID_W    = 32;
    localparam int BSR_W   = 109; // RULE_22
    localparam int BSR_INT = 108; // internal cell, enables test drive

    // RULE_21
    localparam logic [2:0] IR_EXTEST   = 3'h0;
    localparam logic [2:0] IR_IDREAD   = 3'h1;
    localparam logic [2:0] IR_SAMPLE_Z = 3'h2;
    localparam logic [2:0] IR_SAMPLE   = 3'h4;
    localparam logic [2:0] IR_BYPASS   = 3'h7;
    localparam logic [2:0] IR_CAPTURE  = 3'h1; // RULE_08

    typedef enum logic [3:0] {
        ST_EXIT2_DR  = 4'h0,
        ST_EXIT1_DR  = 4'h1,
        ST_SHIFT_DR  = 4'h2,
        ST_PAUSE_DR  = 4'h3,
        ST_SEL_IR    = 4'h4,
        ST_UPDATE_DR = 4'h5,
        ST_CAPT_DR   = 4'h6,
        ST_SEL_DR    = 4'h7,
        ST_EXIT2_IR  = 4'h8,
        ST_EXIT1_IR  = 4'h9,
        ST_SHIFT_IR  = 4'hA,
        ST_PAUSE_IR  = 4'hB,
        ST_IDLE      = 4'hC,
        ST_UPDATE_IR = 4'hD,
        ST_CAPT_IR   = 4'hE,
        ST_RESET     = 4'hF
    } tap_state_t;

    // host timing
    localparam int PCLK_NS      = 8;
    localparam int TCK_PERIOD_NS = 160;
    localparam int TCK_MIN_NS   = 20; // 50 MHz ceiling
    localparam int TCK_HALF_CYC = TCK_PERIOD_NS / (2 * PCLK_NS);
    localparam int RESET_TMS_N  = 5;
    localparam int MAX_BITS     = 128;

    // host registers (byte addresses)
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_TDI0   = 8'h10;
    localparam logic [7:0] OFF_TDO0   = 8'h20;
    localparam int         CTRL_START = 31;
    localparam int         ST_BUSY    = 0;
    localparam int         ST_DONE    = 1;

    typedef enum logic [1:0] {
        OP_RESET = 2'h0,
        OP_IR    = 2'h1,
        OP_DR    = 2'h2
    } op_t;

    typedef enum logic [1:0] {
        PH_IDLE  = 2'h0,
        PH_HEAD  = 2'h1,
        PH_SHIFT = 2'h2,
        PH_TAIL  = 2'h3
    } phase_t;

endpackage

// file: pkg/tap_if.sv
// Purpose: serial test link between board controller and memory port
// Assumes: data-out is three-state; its enable is high while driven
// Notes: the line reads high when undriven, like a pulled-up wire
`timescale 1ns/10ps
`default_nettype none
interface tap_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;

    modport device (input tck, input tms, input tdi,
                    output tdo, output tdo_oe);
    modport host   (output tck, output tms, output tdi,
                    input tdo, input tdo_oe);
endinterface
`default_nettype wire

// file: rtl/tap_device.sv
// Purpose: test access port of the memory: controller, IR, data registers
// Assumes: pclk far faster than the test clock; ring and core on pclk
// Notes: test clock edges found by sampling, no second clock domain
`timescale 1ns/10ps
`default_nettype none
module tap_device #(
    parameter int          Q_W     = 36,
    parameter logic [31:0] ID_CODE = 32'h1000_0A53 // arbitrary value
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    tap_if.device                         link,
    input  wire logic [tap_pkg::BSR_W-1:0] ring_in,
    input  wire logic [Q_W-1:0]           core_q,
    input  wire logic                     core_q_oe,
    output logic      [Q_W-1:0]           q_out,
    output logic                          q_oe
);
    logic tck_s1, tck_s2, tck_s3;
    logic tms_s1, tms_s2;
    logic tdi_s1, tdi_s2;
    logic [tap_pkg::BSR_W-1:0] ring_s1, ring_s2;
    logic tck_rise, tck_fall;

    tap_pkg::tap_state_t state, next_state;
    logic [tap_pkg::IR_W-1:0]  ir, ir_sh;
    logic [tap_pkg::ID_W-1:0]  id_sh;
    logic [tap_pkg::BSR_W-1:0] bsr, upd;
    logic                      byp;

    // every pin input passes two flops; edges come from stage two
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tck_s1  <= 1'b0;
            tck_s2  <= 1'b0;
            tck_s3  <= 1'b0;
            tms_s1  <= 1'b1;
            tms_s2  <= 1'b1;
            tdi_s1  <= 1'b1;
            tdi_s2  <= 1'b1;
            ring_s1 <= '0;
            ring_s2 <= '0;
        end else begin
            tck_s1  <= link.tck;
            tck_s2  <= tck_s1;
            tck_s3  <= tck_s2;
            tms_s1  <= link.tms;
            tms_s2  <= tms_s1;
            tdi_s1  <= link.tdi;
            tdi_s2  <= tdi_s1;
            ring_s1 <= ring_in;
            ring_s2 <= ring_s1;
        end
    end

    assign tck_rise = tck_s2 & ~tck_s3; // RULE_02
    assign tck_fall = ~tck_s2 & tck_s3; // RULE_02

    // standard controller graph
    always_comb begin
        next_state = state;
        case (state)
            tap_pkg::ST_RESET:
                next_state = tms_s2 ? tap_pkg::ST_RESET : tap_pkg::ST_IDLE;
            tap_pkg::ST_IDLE:
                next_state = tms_s2 ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            tap_pkg::ST_SEL_DR:
                next_state = tms_s2 ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAPT_DR;
            tap_pkg::ST_CAPT_DR:
                next_state = tms_s2 ? tap_pkg::ST_EXIT1_DR
                                    : tap_pkg::ST_SHIFT_DR;
            tap_pkg::ST_SHIFT_DR:
                next_state = tms_s2 ? tap_pkg::ST_EXIT1_DR
                                    : tap_pkg::ST_SHIFT_DR;
            tap_pkg::ST_EXIT1_DR:
                next_state = tms_s2 ? tap_pkg::ST_UPDATE_DR
                                    : tap_pkg::ST_PAUSE_DR;
            tap_pkg::ST_PAUSE_DR:
                next_state = tms_s2 ? tap_pkg::ST_EXIT2_DR
                                    : tap_pkg::ST_PAUSE_DR;
            tap_pkg::ST_EXIT2_DR:
                next_state = tms_s2 ? tap_pkg::ST_UPDATE_DR
                                    : tap_pkg::ST_SHIFT_DR;
            tap_pkg::ST_UPDATE_DR:
                next_state = tms_s2 ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            tap_pkg::ST_SEL_IR:
                next_state = tms_s2 ? tap_pkg::ST_RESET : tap_pkg::ST_CAPT_IR;
            tap_pkg::ST_CAPT_IR:
                next_state = tms_s2 ? tap_pkg::ST_EXIT1_IR
                                    : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_SHIFT_IR:
                next_state = tms_s2 ? tap_pkg::ST_EXIT1_IR
                                    : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_EXIT1_IR:
                next_state = tms_s2 ? tap_pkg::ST_UPDATE_IR
                                    : tap_pkg::ST_PAUSE_IR;
            tap_pkg::ST_PAUSE_IR:
                next_state = tms_s2 ? tap_pkg::ST_EXIT2_IR
                                    : tap_pkg::ST_PAUSE_IR;
            tap_pkg::ST_EXIT2_IR:
                next_state = tms_s2 ? tap_pkg::ST_UPDATE_IR
                                    : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_UPDATE_IR:
                next_state = tms_s2 ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            default:
                next_state = tap_pkg::ST_RESET;
        endcase
    end

    // power-up lands in reset; five highs from any state reach it too
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= tap_pkg::ST_RESET; // RULE_01
        end else if (tck_rise) begin
            state <= next_state; // RULE_06
        end
    end

    // instruction register; only the test logic is touched by reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ir    <= tap_pkg::IR_IDREAD; // RULE_07
            ir_sh <= tap_pkg::IR_IDREAD;
        end else if (tck_rise) begin
            case (state)
                // loaded on the way into reset, not one rise later
                tap_pkg::ST_SEL_IR:
                    if (tms_s2) begin
                        ir <= tap_pkg::IR_IDREAD; // RULE_07
                    end
                tap_pkg::ST_CAPT_IR:
                    ir_sh <= tap_pkg::IR_CAPTURE; // RULE_08
                tap_pkg::ST_SHIFT_IR:
                    ir_sh <= {tdi_s2, ir_sh[tap_pkg::IR_W-1:1]}; // RULE_04
                tap_pkg::ST_UPDATE_IR:
                    ir <= ir_sh; // RULE_07
                default: ;
            endcase
        end
    end

    // data registers; reserved codes fall back to the bypass bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            id_sh <= '0;
            byp   <= 1'b0;
            bsr   <= '0;
            upd   <= '0;
        end else if (tck_rise) begin
            case (state)
                tap_pkg::ST_UPDATE_IR: begin
                    if (ir_sh == tap_pkg::IR_BYPASS) begin
                        byp <= 1'b0; // RULE_09
                    end
                end
                tap_pkg::ST_CAPT_DR: begin
                    case (ir)
                        tap_pkg::IR_IDREAD:
                            id_sh <= ID_CODE; // RULE_10
                        tap_pkg::IR_EXTEST,
                        tap_pkg::IR_SAMPLE_Z,
                        tap_pkg::IR_SAMPLE:
                            // internal cell has no pin; it keeps its value
                            bsr <= {bsr[tap_pkg::BSR_INT],
                                    ring_s2[tap_pkg::BSR_INT-1:0]}; // RULE_11
                        default:
                            byp <= 1'b0; // RULE_09
                    endcase
                end
                tap_pkg::ST_SHIFT_DR: begin
                    case (ir) // RULE_05 RULE_21
                        tap_pkg::IR_IDREAD:
                            id_sh <= {tdi_s2, id_sh[tap_pkg::ID_W-1:1]};
                        tap_pkg::IR_EXTEST,
                        tap_pkg::IR_SAMPLE_Z,
                        tap_pkg::IR_SAMPLE:
                            bsr <= {tdi_s2, bsr[tap_pkg::BSR_W-1:1]}; // RULE_04
                        default:
                            byp <= tdi_s2; // RULE_18
                    endcase
                end
                tap_pkg::ST_UPDATE_DR: begin
                    // preload path: update cells move only in these two
                    if (ir == tap_pkg::IR_SAMPLE ||
                        ir == tap_pkg::IR_EXTEST) begin
                        upd <= bsr; // RULE_15
                    end
                end
                default: ;
            endcase
        end
    end

    // serial out moves on the falling test clock edge only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.tdo    <= 1'b0;
            link.tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            link.tdo_oe <= (state == tap_pkg::ST_SHIFT_IR) ||
                           (state == tap_pkg::ST_SHIFT_DR); // RULE_03
            if (state == tap_pkg::ST_SHIFT_IR) begin
                link.tdo <= ir_sh[0]; // RULE_04
            end else begin
                case (ir) // RULE_05
                    tap_pkg::IR_IDREAD:   link.tdo <= id_sh[0];
                    tap_pkg::IR_EXTEST,
                    tap_pkg::IR_SAMPLE_Z,
                    tap_pkg::IR_SAMPLE:   link.tdo <= bsr[0];
                    default:              link.tdo <= byp; // RULE_18
                endcase
            end
        end
    end

    // memory output stage; normal traffic passes outside the test modes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_out <= '0;
            q_oe  <= 1'b0;
        end else begin
            case (ir)
                tap_pkg::IR_SAMPLE_Z: begin
                    q_out <= core_q;
                    q_oe  <= 1'b0; // RULE_14
                end
                tap_pkg::IR_EXTEST: begin
                    q_out <= upd[Q_W-1:0]; // RULE_13
                    q_oe  <= upd[tap_pkg::BSR_INT]; // RULE_13
                end
                default: begin
                    q_out <= core_q; // RULE_06
                    q_oe  <= core_q_oe;
                end
            endcase
        end
    end

endmodule // tap_device
`default_nettype wire

// file: rtl/tap_host.sv
// Purpose: board test controller driving the serial test link from APB
// Assumes: software writes shift data, then starts one scan by CTRL
// Notes: test clock made by dividing pclk; held low when no scan runs
`timescale 1ns/10ps
`default_nettype none
module tap_host #(
    parameter int HALF = tap_pkg::TCK_HALF_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    tap_if.host              link
);
    localparam logic [7:0] HALF_M1 = 8'(HALF - 1);

    logic              tdo_s1, tdo_s2;
    logic [127:0]      din, dout;
    tap_pkg::op_t      op;
    tap_pkg::phase_t   phase, next_phase;
    logic [7:0]        len, idx, next_idx, div;
    logic              busy, done, step, rise, fall, wr, start;
    logic [1:0]        aw;

    function automatic logic [4:0] head_bits(tap_pkg::op_t o);
        case (o)
            tap_pkg::OP_IR: head_bits = 5'h03; // 1,1,0,0: to Shift-IR
            tap_pkg::OP_DR: head_bits = 5'h01; // 1,0,0: to Shift-DR
            default:        head_bits = 5'h1F; // RULE_06
        endcase
    endfunction

    function automatic logic [7:0] head_len(tap_pkg::op_t o);
        case (o)
            tap_pkg::OP_IR: head_len = 8'h04;
            tap_pkg::OP_DR: head_len = 8'h03;
            default:        head_len = 8'(tap_pkg::RESET_TMS_N);
        endcase
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tdo_s1 <= 1'b1;
            tdo_s2 <= 1'b1;
        end else begin
            tdo_s1 <= link.tdo_oe ? link.tdo : 1'b1;
            tdo_s2 <= tdo_s1;
        end
    end

    // APB: one wait state; writes take effect on the pready edge
    assign wr    = psel & penable & pready & pwrite;
    assign aw    = paddr[3:2];
    assign start = wr && paddr == tap_pkg::OFF_CTRL &&
                   pwdata[tap_pkg::CTRL_START] && !busy;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= 1'b0;
            if (psel & penable & ~pready) begin
                prdata <= '0;
                if (paddr == tap_pkg::OFF_CTRL) begin
                    prdata <= {16'h0000, len, 6'h00, op};
                end else if (paddr == tap_pkg::OFF_STATUS) begin
                    prdata <= {30'h0, done, busy};
                end else if (paddr[7:4] == tap_pkg::OFF_TDI0[7:4] &&
                             paddr[1:0] == 2'h0) begin
                    prdata <= din[32*aw +: 32];
                end else if (paddr[7:4] == tap_pkg::OFF_TDO0[7:4] &&
                             paddr[1:0] == 2'h0) begin
                    prdata <= dout[32*aw +: 32];
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            din <= '0;
            op  <= tap_pkg::OP_RESET;
            len <= '0;
        end else if (wr && !busy) begin
            if (paddr == tap_pkg::OFF_CTRL) begin
                op  <= tap_pkg::op_t'(pwdata[1:0]);
                len <= pwdata[15:8];
            end else if (paddr[7:4] == tap_pkg::OFF_TDI0[7:4]) begin
                din[32*aw +: 32] <= pwdata;
            end
        end
    end

    // test clock divider; runs only during a scan
    assign step = busy && div == HALF_M1;
    assign rise = step && !link.tck;
    assign fall = step && link.tck;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div      <= '0;
            link.tck <= 1'b0; // RULE_20
        end else if (!busy) begin
            div      <= '0;
            link.tck <= 1'b0; // RULE_20
        end else begin
            div      <= step ? 8'h00 : div + 8'h01;
            link.tck <= step ? ~link.tck : link.tck; // RULE_16
        end
    end

    always_comb begin
        next_phase = phase;
        next_idx   = idx + 8'h01;
        case (phase)
            tap_pkg::PH_HEAD:
                if (idx == head_len(op) - 8'h01) begin
                    next_idx   = '0;
                    next_phase = (op != tap_pkg::OP_RESET && len != 8'h00)
                                 ? tap_pkg::PH_SHIFT : tap_pkg::PH_TAIL;
                end
            tap_pkg::PH_SHIFT:
                if (idx == len - 8'h01) begin
                    next_idx   = '0;
                    next_phase = tap_pkg::PH_TAIL;
                end
            tap_pkg::PH_TAIL:
                if (idx == 8'h01) begin
                    next_idx   = '0;
                    next_phase = tap_pkg::PH_IDLE;
                end
            default: begin
                next_idx   = '0;
                next_phase = tap_pkg::PH_IDLE;
            end
        endcase
    end

    // new mode and data bits are presented on the falling edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase    <= tap_pkg::PH_IDLE;
            idx      <= '0;
            busy     <= 1'b0;
            link.tms <= 1'b1;
            link.tdi <= 1'b1;
        end else if (start) begin
            phase    <= tap_pkg::PH_HEAD;
            idx      <= '0;
            busy     <= 1'b1;
            link.tms <= 1'(head_bits(tap_pkg::op_t'(pwdata[1:0])));
            link.tdi <= 1'b1;
        end else if (fall) begin
            phase <= next_phase;
            idx   <= next_idx;
            busy  <= next_phase != tap_pkg::PH_IDLE;
            case (next_phase)
                tap_pkg::PH_HEAD:
                    link.tms <= 1'(head_bits(op) >> next_idx[2:0]);
                tap_pkg::PH_SHIFT: begin
                    // last bit leaves shift; update follows in the tail
                    link.tms <= next_idx == len - 8'h01; // RULE_12
                    link.tdi <= din[next_idx[6:0]];
                end
                tap_pkg::PH_TAIL:
                    link.tms <= next_idx == 8'h00; // RULE_12
                default:
                    link.tms <= 1'b0;
            endcase
        end
    end

    // data-out is sampled where the device samples, at the rise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dout <= '0;
        end else if (rise && phase == tap_pkg::PH_SHIFT) begin
            dout[idx[6:0]] <= tdo_s2;
        end
    end

    // done: set by scan end wins over a software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done <= 1'b0;
        end else if (fall && next_phase == tap_pkg::PH_IDLE) begin
            done <= 1'b1;
        end else if (wr && paddr == tap_pkg::OFF_STATUS &&
                     pwdata[tap_pkg::ST_DONE]) begin
            done <= 1'b0;
        end
    end

endmodule // tap_host
`default_nettype wire

// file: verif/tap_checker.sv
// Purpose: watches the serial test link between the two ends
// Assumes: test clock is sampled on pclk with the host's default divider
// Notes: mode select is recorded at each test clock rise
`timescale 1ns/10ps
`default_nettype none
module tap_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    logic       tck_q;
    logic       last_tms;
    logic       rise;
    logic [2:0] hi_cnt;
    assign rise = tck & ~tck_q;
    // saturates at five so the reset check stays armed while tms stays high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tck_q    <= 1'b0;
            last_tms <= 1'b1;
            hi_cnt   <= 3'h0;
        end else begin
            tck_q <= tck;
            if (rise) begin
                last_tms <= tms;
                hi_cnt   <= !tms ? 3'h0 :
                            (hi_cnt == 3'h5 ? 3'h5 : hi_cnt + 3'h1);
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    tdo_edge_a: assert property ($changed(tdo) |-> !tck)
        else $error("data out moved while test clock high");
    oe_edge_a: assert property ($changed(tdo_oe) |-> !tck)
        else $error("data out enable moved while test clock high");
    oe_rise_a: assert property ($rose(tdo_oe) |-> !last_tms)
        else $error("data out enabled outside a shift state");
    oe_fall_a: assert property ($fell(tdo_oe) |-> last_tms)
        else $error("data out released while still shifting");
    tms_reset_a: assert property (hi_cnt == 3'h5 |-> !tdo_oe)
        else $error("data out driven after five mode select highs");
    tms_setup_a: assert property ($changed(tms) |-> !tck)
        else $error("mode select moved while test clock high");
    tdi_setup_a: assert property ($changed(tdi) |-> !tck)
        else $error("serial in moved while test clock high");
    tck_high_a: assert property ($rose(tck) |-> tck [*8])
        else $error("test clock high phase too short");
    tck_low_a: assert property ($fell(tck) |-> !tck [*8])
        else $error("test clock low phase too short");
    cover property ($rose(tdo_oe));
    cover property ($fell(tdo_oe) && last_tms);
    cover property (hi_cnt == 3'h5);
endmodule // tap_checker
`default_nettype wire

// file: verif/sram_jtag_tap_boundary_scan_tb.sv
// Purpose: drives the host over APB and judges scans through the device
// Assumes: host default divider, device with 36 outputs
// Notes: the device is seen only through scans and its pad outputs
`timescale 1ns/10ps
`default_nettype none
module sram_jtag_tap_boundary_scan_tb;
    localparam logic [31:0]  ID  = 32'h0000_5A5B; // arbitrary value
    localparam logic [127:0] PAT = 128'h1ABC_F0E1_D2C3_B4A5_9687_7869_5A4B;
    logic         pclk        = 1'b0;
    logic         presetn     = 1'b0;
    logic         psel        = 1'b0;
    logic         penable     = 1'b0;
    logic         pwrite      = 1'b0;
    logic [7:0]   paddr       = 8'h00;
    logic [31:0]  pwdata      = 32'h0;
    logic [108:0] ring_in     = 109'h1_2345_6789_ABCD_EF01_2345_6789;
    logic [35:0]  core_q      = 36'h9_8765_4321;
    logic         core_q_oe   = 1'b1;
    logic [31:0]  prdata;
    logic [31:0]  rd;
    logic         pready;
    logic         pslverr;
    logic         err;
    logic [35:0]  q_out;
    logic         q_oe;
    logic [127:0] dv;
    int           num_errors  = 0;
    int           check_count = 0;
    always #4 pclk = ~pclk;
    tap_if link ();
    tap_host u_tap_host (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.host));
    tap_device #(.ID_CODE(ID)) u_tap_device (.pclk(pclk), .presetn(presetn),
        .link(link.device), .ring_in(ring_in), .core_q(core_q),
        .core_q_oe(core_q_oe), .q_out(q_out), .q_oe(q_oe));
    tap_checker u_tap_checker (.pclk(pclk), .presetn(presetn), .tck(link.tck),
        .tms(link.tms), .tdi(link.tdi), .tdo(link.tdo), .tdo_oe(link.tdo_oe));
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic [7:0]  a, input logic w,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle count assumed; a dead slave is left to the watchdog
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // result bits land in dv, first bit out at bit 0
    task automatic scan(input logic [1:0] op, input logic [7:0] len,
                        input logic [127:0] din);
        int n;
        for (int i = 0; i < 4; i++) begin
            apb(8'h10 + 8'(4 * i), 1'b1, din[32*i +: 32]);
        end
        apb(tap_pkg::OFF_CTRL, 1'b1, {1'b1, 15'h0, len, 6'h0, op});
        n = 0;
        do begin
            apb(tap_pkg::OFF_STATUS, 1'b0, 32'h0);
            n++;
        end while (rd[tap_pkg::ST_DONE] !== 1'b1 && n < 2000);
        if (rd[tap_pkg::ST_DONE] !== 1'b1) begin
            num_errors++;
            complete_run();
        end
        apb(tap_pkg::OFF_STATUS, 1'b1, 32'h2);
        for (int i = 0; i < 4; i++) begin
            apb(8'h20 + 8'(4 * i), 1'b0, 32'h0);
            dv[32*i +: 32] = rd;
        end
    endtask
    task automatic ir(input logic [2:0] code);
        scan(tap_pkg::OP_IR, 8'h03, {125'h0, code});
    endtask
    task automatic t_idcode();
        scan(tap_pkg::OP_RESET, 8'h01, 128'h0);
        scan(tap_pkg::OP_DR, 8'h20, 128'h0);
        check(dv[31:0], ID);
        ir(tap_pkg::IR_IDREAD);
        check(dv[2:0], tap_pkg::IR_CAPTURE);
        scan(tap_pkg::OP_DR, 8'h20, 128'h0);
        check(dv[31:0], ID);
    endtask
    task automatic t_bypass();
        ir(tap_pkg::IR_BYPASS);
        scan(tap_pkg::OP_DR, 8'h03, 128'h3);
        check(dv[2:0], 3'h6);
    endtask
    task automatic t_sample_extest();
        ir(tap_pkg::IR_SAMPLE);
        scan(tap_pkg::OP_DR, 8'h6D, PAT);
        check(dv[107:0], ring_in[107:0]);
        check({q_oe, q_out}, {core_q_oe, core_q});
        ir(tap_pkg::IR_EXTEST);
        check({q_oe, q_out}, {PAT[108], PAT[35:0]});
    endtask
    task automatic t_sample_z();
        ring_in <= ~ring_in;
        ir(tap_pkg::IR_SAMPLE_Z);
        check(q_oe, 1'b0);
        scan(tap_pkg::OP_DR, 8'h6D, PAT);
        check(dv[107:0], ring_in[107:0]);
    endtask
    task automatic t_reset();
        scan(tap_pkg::OP_RESET, 8'h01, 128'h0);
        check({q_oe, q_out}, {core_q_oe, core_q});
        scan(tap_pkg::OP_DR, 8'h20, 128'h0);
        check(dv[31:0], ID);
        apb(8'hF0, 1'b0, 32'h0);
        check({err, rd}, {1'b1, 32'h0});
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_idcode();
        t_bypass();
        t_sample_extest();
        t_sample_z();
        t_reset();
        complete_run();
    end
    initial begin
        #400000;
        num_errors++;
        complete_run();
    end
endmodule // sram_jtag_tap_boundary_scan_tb
`default_nettype wire
